/* dv/dscr_host_model.sv */
// serial master model that frames commands and collects the answer word
`timescale 1ns/10ps
module dscr_host_model (
  output logic sclk_o,
  output logic frame_sync_n_o,
  output logic serial_data_in_o,
  input  wire logic serial_data_out_i,
  input  wire logic serial_data_out_oe_i,
  output logic oe_seen_o
);
  // ****************************************************************
  // idle levels: clock stands low, frame inactive
  // ****************************************************************
  initial begin
    sclk_o           = 1'b0;
    frame_sync_n_o   = 1'b1;
    serial_data_in_o = 1'b0;
    oe_seen_o        = 1'b0;
  end

  // sends nbits of a frame and returns the word shifted out meanwhile
  // frame layout chosen by caller
  task automatic xfer(input logic [23:0] f, input int nbits, output logic [23:0] ans);
    ans = 24'h000000;
    #3 frame_sync_n_o = 1'b0;
    #40;
    for (int i = 23; i > 23 - nbits; i--) begin
      serial_data_in_o = f[i];
      #40 sclk_o = 1'b1;
      #40;
      // a floating output reads as the inverse, never as a stale level
      ans[i] = serial_data_out_oe_i ? serial_data_out_i : ~serial_data_out_i;
      oe_seen_o = serial_data_out_oe_i;
      sclk_o = 1'b0;
    end
    #40 frame_sync_n_o = 1'b1;
    // released line shows the inverse so a stale level is never trusted
    serial_data_in_o = ~serial_data_in_o;
  endtask : xfer
endmodule : dscr_host_model

/* dv/test_dscr_top.sv */
// self-checking bench of the serial command decoder
`timescale 1ns/10ps
module test_dscr_top;
  import dscr_pkg::*;
  logic        sys_clk_i;
  logic        rstn_i;
  logic        strobe_n;
  logic        sc;
  logic        bo;
  wire logic   sclk;
  wire logic   fs_n;
  wire logic   serial_data_in;
  wire logic   serial_data_out;
  wire logic   oe;
  wire logic   oe_seen;
  logic [15:0] dac_code;
  logic        output_on;
  dscr_ctrl_t  ctrl;
  logic [23:0] ans;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          cycles     = 0;

  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  initial sys_clk_i = 1'b0;
  always #4 sys_clk_i = ~sys_clk_i;

  dscr_top uut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .frame_sync_n_i(fs_n),
    .serial_data_in_i(serial_data_in), .load_output_strobe_n_i(strobe_n), .short_circuit_i(sc),
    .brownout_i(bo), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe),
    .dac_code_o(dac_code), .output_on_o(output_on), .ctrl_o(ctrl)
  );

  dscr_host_model host (
    .sclk_o(sclk), .frame_sync_n_o(fs_n), .serial_data_in_o(serial_data_in),
    .serial_data_out_i(serial_data_out), .serial_data_out_oe_i(oe), .oe_seen_o(oe_seen)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one frame, then time for the effect to reach the system side
  task automatic send(input logic [23:0] f, input int n = 24);
    host.xfer(f, n, ans);
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask : send

  task automatic test_end(input string name);
    $display("done %s", name);
  endtask : test_end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // cuts a hang short well above the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rstn_i   = 1'b0;
    strobe_n = 1'b1;
    sc       = 1'b0;
    bo       = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("dac_code", 24'h000000, {8'h00, dac_code});
    chk("output_on", 24'h000000, {23'h000000, output_on});
    chk("ctrl", 24'h000000, {13'h0000, ctrl});
    test_end("reset");
    send(24'h04F787);
    chk("ctrl", 24'h000787, {13'h0000, ctrl});
    chk("output_on", 24'h000001, {23'h000000, output_on});
    chk("output enable", 24'h000001, {23'h000000, oe_seen});
    test_end("control write");
    send(24'hE1A5C3);
    chk("dac_code", 24'h000000, {8'h00, dac_code});
    send(24'h0AFFFF);
    chk("chain word", 24'hE1A5C3, ans);
    send(24'h000000);
    chk("input readback", 24'h0AA5C3, ans);
    test_end("input register");
    send(24'h02FFFF);
    chk("dac_code", 24'h00A5C3, {8'h00, dac_code});
    send(24'h0B5A5A);
    send(24'h000000);
    chk("dac readback", 24'h0BA5C3, ans);
    send(24'h031234);
    chk("dac_code", 24'h001234, {8'h00, dac_code});
    test_end("dac register");
    strobe_n = 1'b0;
    send(24'h014321);
    chk("dac_code", 24'h004321, {8'h00, dac_code});
    strobe_n = 1'b1;
    send(24'h03FFFF, 20);
    chk("dac_code", 24'h004321, {8'h00, dac_code});
    send(24'h000000);
    chk("word after short frame", 24'h014321, ans);
    test_end("strobe and short frame");
    sc = 1'b1;
    bo = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1 sc = 1'b0;
    bo = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    send(24'h0C0000);
    send(24'h000000);
    chk("control readback", 24'h0C1F87, ans);
    test_end("flags");
    // straight binary then twos complement midscale on the bipolar range
    for (int k = 0; k < 2; k++) begin
      send({16'h0400, (k == 1) ? 8'h80 : 8'h00});
      send((k == 1) ? 24'h030000 : 24'h038000);
      chk("bipolar midscale", 24'h008000, {8'h00, dac_code});
    end
    send(24'h0C0000);
    send(24'h000000);
    chk("control readback", 24'h0C0080, ans);
    test_end("coding");
    send(24'h090001);
    send(24'h0C0000);
    chk("output enable", 24'h000000, {23'h000000, oe_seen});
    send(24'h090000);
    send(24'h000000);
    chk("output enable", 24'h000001, {23'h000000, oe_seen});
    test_end("chain disable");
    // reset in mid-run returns the device to its unconfigured state
    rstn_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("output_on", 24'h000000, {23'h000000, output_on});
    chk("ctrl", 24'h000000, {13'h0000, ctrl});
    send(24'h0A0000);
    send(24'h000000);
    chk("input readback", 24'h0A0000, ans);
    test_end("second reset");
    conclude();
  end
endmodule : test_dscr_top

/* rtl/dscr_pkg.sv */
// constants and types of the serial command decoder for a one-channel dac
// ****************************************************************
// Behaviour
// - bipolar codes: twos complement inverts the msb
// - command 1100 asks control readback, data ignored
// - readback word leaves msb first next frame
// - control word: zero, 1100, flags, control fields
// - short circuit flag set, cleared by control write
// - brownout flag set, cleared by control write
// - command 0010 copies input into dac register
// - command 1011 asks dac readback, data ignored
// - dac readback word carries 1011 and dac data
// - command 0011 loads both registers ignoring strobe
// - command 0001 writes input register, and dac register too while strobe is low, msb first
// - command 1010 asks input readback, data ignored
// - input readback word carries input register data
// - frame: three spare, zero, command, sixteen data
// - command 0100 writes control and enables output
// - chain disabled: output floats, no readback
// ****************************************************************
package dscr_pkg;

  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS  = 16;
  localparam int CNT_W      = 5;

  localparam logic [CNT_W-1:0] CNT_LAST = 5'h17;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;

  localparam logic [3:0] CMD_WR_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE   = 4'h2;
  localparam logic [3:0] CMD_WR_UPD   = 4'h3;
  localparam logic [3:0] CMD_WR_CTRL  = 4'h4;
  localparam logic [3:0] CMD_CHAIN    = 4'h9;
  localparam logic [3:0] CMD_RB_INPUT = 4'hA;
  localparam logic [3:0] CMD_RB_DAC   = 4'hB;
  localparam logic [3:0] CMD_RB_CTRL  = 4'hC;

  // bipolar range codes of output_range_select
  localparam logic [2:0] RANGE_PM10   = 3'h0;
  localparam logic [2:0] RANGE_PM5    = 3'h2;
  localparam logic [2:0] RANGE_M25P75 = 3'h4;
  localparam logic [2:0] RANGE_PM3    = 3'h5;

  localparam int CTRL_BITS = 11;
  localparam int MSB_POS   = 15;

  // control register, db10 down to db0
  typedef struct packed {
    logic [1:0] clear_value_select;
    logic       overrange_enable;
    logic       bipolar_coding_select;
    logic       thermal_shutdown_enable;
    logic       spare;
    logic [1:0] powerup_value_select;
    logic [2:0] output_range_select;
  } dscr_ctrl_t;

  // one 24 bit frame, db23 first
  typedef struct packed {
    logic [2:0]  pad;
    logic        zero;
    logic [3:0]  cmd;
    logic [15:0] data;
  } dscr_frame_t;

  localparam dscr_ctrl_t CTRL_RESET = '0;

endpackage : dscr_pkg

/* rtl/dscr_top.sv */
// serial command decoder with readback for a one-channel dac
`timescale 1ns/10ps
module dscr_top
  import dscr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       sclk_i,
  input  wire logic       frame_sync_n_i,
  input  wire logic       serial_data_in_i,
  input  wire logic       load_output_strobe_n_i,
  input  wire logic       short_circuit_i,
  input  wire logic       brownout_i,
  output logic            serial_data_out_o,
  output logic            serial_data_out_oe_o,
  output logic [15:0]     dac_code_o,
  output logic            output_on_o,
  output dscr_ctrl_t      ctrl_o
);

  // ****************************************************************
  // link side, clocked by the serial clock
  // ****************************************************************
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [22:0]      rx_shift_reg;
  dscr_frame_t      frame_hold_reg;
  logic             frame_tgl_reg;
  logic [22:0]      tx_shift_reg;
  logic             sdo_reg;
  logic             sdo_oe_reg;
  logic             link_rstn;

  // frame select high clears the bit count, so a short frame is dropped
  assign link_rstn = rstn_i & ~frame_sync_n_i;

  // bit counter and receive shift
  always_ff @(posedge sclk_i or negedge link_rstn) begin
    if (!link_rstn) begin
      bit_cnt_reg  <= '0;
      rx_shift_reg <= '0;
    end else if (bit_cnt_reg != CNT_FULL) begin
      bit_cnt_reg  <= bit_cnt_reg + 5'h01;
      rx_shift_reg <= {rx_shift_reg[21:0], serial_data_in_i};
    end
  end

  // capture only on the 24th bit
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_hold_reg <= '0;
      frame_tgl_reg  <= 1'b0;
    end else if (!frame_sync_n_i && bit_cnt_reg == CNT_LAST) begin
      frame_hold_reg <= {rx_shift_reg, serial_data_in_i};
      frame_tgl_reg  <= ~frame_tgl_reg;
    end
  end

  dscr_frame_t out_word_reg;
  logic        chain_dis_reg;

  // load the answer at the first edge, then shift msb first
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdo_reg      <= 1'b0;
      tx_shift_reg <= '0;
      sdo_oe_reg   <= 1'b1;
    end else if (!frame_sync_n_i) begin
      if (bit_cnt_reg == '0) begin
        sdo_reg      <= out_word_reg[FRAME_BITS-1];
        tx_shift_reg <= out_word_reg[FRAME_BITS-2:0];
        sdo_oe_reg   <= ~chain_dis_reg;
      end else if (bit_cnt_reg != CNT_FULL) begin
        sdo_reg      <= tx_shift_reg[22];
        tx_shift_reg <= {tx_shift_reg[21:0], 1'b0};
      end
    end
  end

  assign serial_data_out_o    = sdo_reg;
  assign serial_data_out_oe_o = sdo_oe_reg;

  // ****************************************************************
  // system side: synchronisers
  // ****************************************************************
  logic [2:0] tgl_sync_reg;
  logic [1:0] load_output_strobe_sync_reg;
  logic [1:0] sc_sync_reg;
  logic [1:0] bo_sync_reg;
  logic       frame_evt;

  // two flops per pin, a third stage for the toggle edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_sync_reg  <= '0;
      load_output_strobe_sync_reg <= 2'h3;
      sc_sync_reg   <= '0;
      bo_sync_reg   <= '0;
    end else begin
      tgl_sync_reg  <= {tgl_sync_reg[1:0], frame_tgl_reg};
      load_output_strobe_sync_reg <= {load_output_strobe_sync_reg[0], load_output_strobe_n_i};
      sc_sync_reg   <= {sc_sync_reg[0], short_circuit_i};
      bo_sync_reg   <= {bo_sync_reg[0], brownout_i};
    end
  end

  // frame hold is stable for many cycles once the toggle arrives
  assign frame_evt = tgl_sync_reg[2] ^ tgl_sync_reg[1];

  dscr_frame_t fr;
  logic        wr_ctrl;
  assign fr      = frame_hold_reg;
  assign wr_ctrl = frame_evt && fr.cmd == CMD_WR_CTRL;

  // ****************************************************************
  // system side: registers
  // ****************************************************************
  logic [15:0] input_holding_reg;
  logic [15:0] dac_output_reg;
  dscr_ctrl_t  control_reg;
  logic        short_circuit_flag_reg;
  logic        brownout_flag_reg;
  logic        output_on_reg;
  logic [15:0] dac_code_reg;

  // input register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      input_holding_reg <= '0;
    end else if (frame_evt && (fr.cmd == CMD_WR_INPUT || fr.cmd == CMD_WR_UPD)) begin
      // input written from the data bits
      input_holding_reg <= fr.data;
    end
  end

  // dac register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dac_output_reg <= '0;
    end else if (frame_evt && fr.cmd == CMD_WR_UPD) begin
      dac_output_reg <= fr.data;
    end else if (frame_evt && fr.cmd == CMD_UPDATE) begin
      dac_output_reg <= input_holding_reg;
    end else if (!load_output_strobe_sync_reg[1]) begin
      dac_output_reg <= input_holding_reg; // strobe low tracks input
    end
  end

  // control register and output release
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control_reg   <= CTRL_RESET;
      output_on_reg <= 1'b0;
    end else if (wr_ctrl) begin
      // control write configures and releases output
      control_reg       <= fr.data[CTRL_BITS-1:0];
      control_reg.spare <= 1'b0;
      output_on_reg     <= 1'b1;
    end
  end

  // short circuit flag, set beats clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      short_circuit_flag_reg <= 1'b0;
    end else if (sc_sync_reg[1]) begin
      short_circuit_flag_reg <= 1'b1;
    end else if (wr_ctrl) begin
      short_circuit_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brownout_flag_reg <= 1'b0;
    end else if (bo_sync_reg[1]) begin
      brownout_flag_reg <= 1'b1;
    end else if (wr_ctrl) begin
      brownout_flag_reg <= 1'b0;
    end
  end

  // chain disable, data bit 0 of its command frame
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chain_dis_reg <= 1'b0;
    end else if (frame_evt && fr.cmd == CMD_CHAIN) begin
      chain_dis_reg <= fr.data[0];
    end
  end

  // ****************************************************************
  // system side: answer word for the next frame
  // ****************************************************************
  dscr_frame_t out_word_next;

  always_comb begin
    out_word_next = out_word_reg;
    if (frame_evt) begin
      // default: the frame just received passes on
      out_word_next = fr;
      if (!chain_dis_reg) begin
        // readback words: zero pad, zero, command, data
        if (fr.cmd == CMD_RB_CTRL) begin
          out_word_next = {4'h0, CMD_RB_CTRL, 3'h0, short_circuit_flag_reg,
                           brownout_flag_reg, control_reg};
        end else if (fr.cmd == CMD_RB_DAC) begin
          out_word_next = {4'h0, CMD_RB_DAC, dac_output_reg};
        end else if (fr.cmd == CMD_RB_INPUT) begin
          out_word_next = {4'h0, CMD_RB_INPUT, input_holding_reg};
        end
      end
    end
  end

  // answer word register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_word_reg <= '0;
    end else begin
      out_word_reg <= out_word_next;
    end
  end

  // twos complement bipolar coding flips the msb
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dac_code_reg <= '0;
    end else begin
      dac_code_reg <= dac_output_reg;
      if (control_reg.bipolar_coding_select &&
          (control_reg.output_range_select == RANGE_PM10 ||
           control_reg.output_range_select == RANGE_PM5 ||
           control_reg.output_range_select == RANGE_M25P75 ||
           control_reg.output_range_select == RANGE_PM3)) begin
        dac_code_reg[MSB_POS] <= ~dac_output_reg[MSB_POS];
      end
    end
  end

  assign dac_code_o  = dac_code_reg;
  assign output_on_o = output_on_reg;
  assign ctrl_o      = control_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  sc_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_ctrl && !sc_sync_reg[1] |=> !short_circuit_flag_reg)
    else $error("short circuit flag not cleared");

  bo_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    bo_sync_reg[1] |=> brownout_flag_reg)
    else $error("brownout flag not set");

  bo_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    brownout_flag_reg && !wr_ctrl |=> brownout_flag_reg)
    else $error("brownout flag not held");

  input_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && fr.cmd == CMD_WR_INPUT && load_output_strobe_sync_reg[1]
    |=> input_holding_reg == $past(fr.data) && $stable(dac_output_reg))
    else $error("input write wrong");

  wr_upd_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && fr.cmd == CMD_WR_UPD
    |=> dac_output_reg == $past(fr.data) ##2 dac_code_o[14:0] == $past(fr.data[14:0], 3))
    else $error("write and update wrong");

  update_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && fr.cmd == CMD_UPDATE |=> dac_output_reg == $past(input_holding_reg))
    else $error("update from input wrong");

  rb_ctrl_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && fr.cmd == CMD_RB_CTRL && !chain_dis_reg
    |=> out_word_reg.cmd == CMD_RB_CTRL && !out_word_reg.zero
        && out_word_reg.data[12] == $past(short_circuit_flag_reg))
    else $error("control readback word wrong");

  rb_dac_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && fr.cmd == CMD_RB_DAC && !chain_dis_reg
    |=> out_word_reg.data == $past(dac_output_reg) && out_word_reg.cmd == CMD_RB_DAC)
    else $error("dac readback word wrong");

  rb_input_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && fr.cmd == CMD_RB_INPUT && !chain_dis_reg
    |=> out_word_reg.data == $past(input_holding_reg))
    else $error("input readback word wrong");

  chain_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_evt && (chain_dis_reg || fr.cmd[3:2] == 2'h0) |=> out_word_reg == $past(fr))
    else $error("frame not passed on");

  first_bit_a: assert property (@(posedge sclk_i) disable iff (!rstn_i)
    !frame_sync_n_i && bit_cnt_reg == '0 |=> sdo_reg == $past(out_word_reg[FRAME_BITS-1]))
    else $error("first output bit wrong");

  float_a: assert property (@(posedge sclk_i) disable iff (!rstn_i)
    !frame_sync_n_i && bit_cnt_reg == '0 && chain_dis_reg |=> !sdo_oe_reg)
    else $error("output driven while chain disabled");

endmodule : dscr_top
